// file: core/scr_defs.vh
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// ****************************************
// Register word indices (byte address = 4 * index)
// ****************************************
`define SCR_IDX_CONTROL   8'hc3
`define SCR_IDX_STATUS    8'hc4
`define SCR_IDX_DATA      8'hc5

// ****************************************
// Control field positions and reset value
// ****************************************
`define SCR_CTL_RATE_HI   7
`define SCR_CTL_ENABLE    6
`define SCR_CTL_SEL_IGN   5
`define SCR_CTL_MASTER    4
`define SCR_CTL_IDLE_LVL  3
`define SCR_CTL_PHASE     2
`define SCR_CTL_RATE_MID  1
`define SCR_CTL_RATE_LO   0
`define SCR_CTL_RESET     8'h14

// ****************************************
// Status field positions and reset value
// ****************************************
`define SCR_STA_DONE      7
`define SCR_STA_WRITE_COLLISION_FLAG      6
`define SCR_STA_ABORT     5
`define SCR_STA_MODE_FAULT_FLAG      4
`define SCR_STA_RESET     8'h00

// ****************************************
// Timing counts
// ****************************************
`define SCR_EDGES_LAST    4'hf

`endif

// file: core/scr_top.v
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Rate code divides clock 4..128, reserved idle
// - Enable bit switches the port on/off
// - Select-ignore bit masks slave select input
// - Slave with phase 0 always honours select
// - Master-select bit picks master or slave
// - Idle level bit sets resting clock level
// - Phase bit picks sample and shift edges
// - Control resets to 0x14
// - Done flag set at byte end, cleared
// - Collision flag set on collision, cleared
// - Abort flag on early deselect, enable clears
// - Mode fault clears by its sequence
// - Status low nibble reserved, reads zero
// - Status at index c4, resets zero
// - Data write loads shift register directly
// - Data read returns receive buffer
// - Data register at index c5
// - Registers freely accessible while idle
// - Clearing enable abandons transfer at once
// - Data write mid-transfer is a write collision
// - Master, select low, ignore bit clear: fault, drop enable/master
// - Status then data read clears done
// - Status read then control write clears fault
// - Done drives an interrupt request; fault does only while select-ignore is clear
`include "scr_defs.vh"

module scr_top (
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire [9:0]  ADR_I,
  input  wire [31:0] DAT_I,
  output wire [31:0] DAT_O,
  input  wire        WE_I,
  input  wire [3:0]  SEL_I,
  input  wire        STB_I,
  input  wire        CYC_I,
  output wire        ACK_O,
  input  wire        SCK_I,
  output wire        SCK_O,
  output wire        SCK_OE,
  input  wire        MOSI_I,
  output wire        MOSI_O,
  output wire        MOSI_OE,
  input  wire        MISO_I,
  output wire        MISO_O,
  output wire        MISO_OE,
  input  wire        SEL_N_I,
  output wire        TX_IRQ,
  output wire        RX_ERR_IRQ
);

  // ****************************************
  // Half period of the master clock, 0 = reserved
  // ****************************************
  function [6:0] half_period;
    input [2:0] code;
    begin
      case (code)
        3'h1:    half_period = 7'h02;
        3'h2:    half_period = 7'h04;
        3'h3:    half_period = 7'h08;
        3'h4:    half_period = 7'h10;
        3'h5:    half_period = 7'h20;
        3'h6:    half_period = 7'h40;
        default: half_period = 7'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  reg        rst_meta_r;
  reg        rst_n_r;
  reg  [3:0] pin_meta_r;
  reg  [3:0] pin_sync_r;
  reg        sck_prev_r;

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Order: select, miso, mosi, sck
  always @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 4'hf;
      pin_sync_r <= 4'hf;
      // Matches the synchroniser so no false edge follows reset
      sck_prev_r <= 1'b1;
    end else begin
      pin_meta_r <= {SEL_N_I, MISO_I, MOSI_I, SCK_I};
      pin_sync_r <= pin_meta_r;
      sck_prev_r <= pin_sync_r[0];
    end
  end

  wire sck_s  = pin_sync_r[0];
  wire mosi_s = pin_sync_r[1];
  wire miso_s = pin_sync_r[2];
  wire ss_low = ~pin_sync_r[3];

  // ****************************************
  // State
  // ****************************************
  reg  [7:0]  ctrl_r,    ctrl_nxt;
  reg         done_r,    done_nxt;
  reg         write_collision_flag_r,    write_collision_flag_nxt;
  reg         abort_r,   abort_nxt;
  reg         mode_fault_flag_r,    mode_fault_flag_nxt;
  reg         done_arm_r, done_arm_nxt;
  reg         write_collision_flag_arm_r, write_collision_flag_arm_nxt;
  reg         mode_fault_flag_arm_r, mode_fault_flag_arm_nxt;
  reg  [7:0]  tx_r,      tx_nxt;
  reg  [7:0]  rx_r,      rx_nxt;
  reg  [7:0]  rxbuf_r,   rxbuf_nxt;
  reg  [3:0]  edge_r,    edge_nxt;
  reg         busy_r,    busy_nxt;
  reg  [1:0]  msmp_r,    msmp_nxt;
  reg  [1:0]  mfin_r,    mfin_nxt;
  reg  [6:0]  div_r,     div_nxt;
  reg         sck_r,     sck_nxt;
  reg         sck_oe_r,  sck_oe_nxt;
  reg         mosi_oe_r, mosi_oe_nxt;
  reg         miso_oe_r, miso_oe_nxt;
  reg         err_irq_r, err_irq_nxt;
  reg         ack_r;
  reg  [7:0]  rdata_r,   rdata_nxt;

  // ****************************************
  // Bus decode
  // ****************************************
  wire [7:0] idx     = ADR_I[9:2];
  wire       req     = CYC_I & STB_I & ~ack_r;
  // Side effects land on the acknowledged edge, request still held
  wire       take    = CYC_I & STB_I & ack_r;
  wire       wr      = take & WE_I & SEL_I[0];
  wire       rd      = take & ~WE_I;
  wire       wr_ctrl = wr & (idx == `SCR_IDX_CONTROL);
  wire       wr_data = wr & (idx == `SCR_IDX_DATA);
  wire       rd_stat = rd & (idx == `SCR_IDX_STATUS);
  wire       rd_data = rd & (idx == `SCR_IDX_DATA);

  wire       en      = ctrl_r[`SCR_CTL_ENABLE];
  wire       master_select    = ctrl_r[`SCR_CTL_MASTER];
  wire       clock_edge_phase    = ctrl_r[`SCR_CTL_PHASE];
  wire [2:0] rate    = {ctrl_r[`SCR_CTL_RATE_HI],
                        ctrl_r[`SCR_CTL_RATE_MID],
                        ctrl_r[`SCR_CTL_RATE_LO]};
  wire [6:0] half    = half_period(rate);

  // ****************************************
  // Next-state logic
  // ****************************************
  reg        ss_used;
  reg        slave_sel;
  reg        m_edge;
  reg        edge_ev;
  reg        sample;
  reg        in_bit;

  always @* begin
    ctrl_nxt     = ctrl_r;
    done_nxt     = done_r;
    write_collision_flag_nxt     = write_collision_flag_r;
    abort_nxt    = abort_r;
    mode_fault_flag_nxt     = mode_fault_flag_r;
    done_arm_nxt = done_arm_r;
    write_collision_flag_arm_nxt = write_collision_flag_arm_r;
    mode_fault_flag_arm_nxt = mode_fault_flag_arm_r;
    tx_nxt       = tx_r;
    rx_nxt       = rx_r;
    rxbuf_nxt    = rxbuf_r;
    edge_nxt     = edge_r;
    busy_nxt     = busy_r;
    msmp_nxt     = {msmp_r[0], 1'b0};
    mfin_nxt     = {mfin_r[0], 1'b0};
    div_nxt      = div_r;
    sck_nxt      = sck_r;
    rdata_nxt    = 8'h00;

    // Slave with phase 0 needs select to frame bytes
    ss_used   = ~ctrl_r[`SCR_CTL_SEL_IGN] | (~master_select & ~clock_edge_phase);
    slave_sel = en & ~master_select & (~ss_used | ss_low);
    in_bit    = master_select ? miso_s : mosi_s;

    // Master clock from the divider
    m_edge = 1'b0;
    if (en & master_select & busy_r & (mfin_r == 2'b00) &
        (half != 7'h00)) begin
      div_nxt = div_r + 7'h01;
      if (div_r == half - 7'h01) begin
        div_nxt = 7'h00;
        sck_nxt = ~sck_r;
        m_edge  = 1'b1;
      end
    end
    // Slave clock from the pin
    edge_ev = m_edge | (slave_sel & (sck_s != sck_prev_r));

    // Even edges lead; phase picks which edge samples
    sample = ~edge_r[0] ^ clock_edge_phase;
    if (edge_ev) begin
      busy_nxt = 1'b1;
      done_nxt = 1'b0;
      edge_nxt = edge_r + 4'h1;
      if (sample) begin
        if (master_select)
          msmp_nxt[0] = 1'b1;
        else
          rx_nxt = {rx_r[6:0], in_bit};
      end else if (edge_r != 4'h0) begin
        tx_nxt = {tx_r[6:0], 1'b0};
      end
      if (edge_r == `SCR_EDGES_LAST) begin
        edge_nxt = 4'h0;
        if (master_select) begin
          mfin_nxt[0] = 1'b1;
        end else begin
          busy_nxt  = 1'b0;
          rxbuf_nxt = sample ? {rx_r[6:0], in_bit} : rx_r;
        end
      end
    end

    // Pin synchroniser lags the master's own clock by two cycles,
    // so its samples and the byte end are taken two cycles late
    if (msmp_r[1])
      rx_nxt = {rx_r[6:0], miso_s};
    if (mfin_r[1]) begin
      busy_nxt  = 1'b0;
      rxbuf_nxt = msmp_r[1] ? {rx_r[6:0], miso_s} : rx_r;
    end

    // Early deselect of a selected slave
    if (en & ~master_select & ss_used & ~ss_low & busy_r) begin
      abort_nxt = 1'b1;
      busy_nxt  = 1'b0;
      edge_nxt  = 4'h0;
    end

    // Clearing sequences; a same-cycle set below wins
    // Arm on the flags the master actually saw
    if (rd_stat) begin
      done_arm_nxt = rdata_r[`SCR_STA_DONE];
      write_collision_flag_arm_nxt = rdata_r[`SCR_STA_WRITE_COLLISION_FLAG];
      mode_fault_flag_arm_nxt = rdata_r[`SCR_STA_MODE_FAULT_FLAG];
    end
    if (rd_data & done_arm_r) begin
      done_nxt     = 1'b0;
      done_arm_nxt = 1'b0;
    end
    if ((rd_data | wr_data) & write_collision_flag_arm_r) begin
      write_collision_flag_nxt     = 1'b0;
      write_collision_flag_arm_nxt = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_nxt = DAT_I[7:0];
      if (mode_fault_flag_arm_r) begin
        mode_fault_flag_nxt     = 1'b0;
        mode_fault_flag_arm_nxt = 1'b0;
      end
    end

    // No holding buffer: the byte goes straight to the shifter
    if (wr_data) begin
      tx_nxt = DAT_I[7:0];
      if (busy_r) begin
        write_collision_flag_nxt = 1'b1;
      end else if (en & master_select & (half != 7'h00)) begin
        busy_nxt = 1'b1;
        done_nxt = 1'b0;
        div_nxt  = 7'h00;
        edge_nxt = 4'h0;
      end
    end

    if ((edge_ev & (edge_r == `SCR_EDGES_LAST) & ~master_select) | mfin_r[1])
      done_nxt = 1'b1;

    // Another master pulled select low
    if (en & master_select & ~ctrl_r[`SCR_CTL_SEL_IGN] & ss_low) begin
      mode_fault_flag_nxt                 = 1'b1;
      ctrl_nxt[`SCR_CTL_ENABLE] = 1'b0;
      ctrl_nxt[`SCR_CTL_MASTER] = 1'b0;
      busy_nxt                 = 1'b0;
      edge_nxt                 = 4'h0;
      msmp_nxt                 = 2'b00;
      mfin_nxt                 = 2'b00;
    end

    // Disabled port drops any transfer at once
    if (~en) begin
      busy_nxt  = 1'b0;
      edge_nxt  = 4'h0;
      div_nxt   = 7'h00;
      msmp_nxt  = 2'b00;
      mfin_nxt  = 2'b00;
      abort_nxt = 1'b0;
    end
    if (~busy_nxt)
      sck_nxt = ctrl_nxt[`SCR_CTL_IDLE_LVL];

    case (idx)
      `SCR_IDX_CONTROL: rdata_nxt = ctrl_r;
      `SCR_IDX_STATUS:  rdata_nxt = {done_r, write_collision_flag_r, abort_r, mode_fault_flag_r,
                                     4'h0};
      `SCR_IDX_DATA:    rdata_nxt = rxbuf_r;
      default:          rdata_nxt = 8'h00;
    endcase
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always @* begin
    sck_oe_nxt  = ctrl_nxt[`SCR_CTL_ENABLE] & ctrl_nxt[`SCR_CTL_MASTER];
    mosi_oe_nxt = sck_oe_nxt;
    miso_oe_nxt = slave_sel;
    err_irq_nxt = mode_fault_flag_nxt & ~ctrl_nxt[`SCR_CTL_SEL_IGN];
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r     <= `SCR_CTL_RESET;
      done_r     <= 1'b0;
      write_collision_flag_r     <= 1'b0;
      abort_r    <= 1'b0;
      mode_fault_flag_r     <= 1'b0;
      done_arm_r <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
      tx_r       <= 8'h00;
      rx_r       <= 8'h00;
      rxbuf_r    <= 8'h00;
      edge_r     <= 4'h0;
      busy_r     <= 1'b0;
      msmp_r     <= 2'b00;
      mfin_r     <= 2'b00;
      div_r      <= 7'h00;
      sck_r      <= 1'b0;
      sck_oe_r   <= 1'b0;
      mosi_oe_r  <= 1'b0;
      miso_oe_r  <= 1'b0;
      err_irq_r  <= 1'b0;
      ack_r      <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      ctrl_r     <= ctrl_nxt;
      done_r     <= done_nxt;
      write_collision_flag_r     <= write_collision_flag_nxt;
      abort_r    <= abort_nxt;
      mode_fault_flag_r     <= mode_fault_flag_nxt;
      done_arm_r <= done_arm_nxt;
      write_collision_flag_arm_r <= write_collision_flag_arm_nxt;
      mode_fault_flag_arm_r <= mode_fault_flag_arm_nxt;
      tx_r       <= tx_nxt;
      rx_r       <= rx_nxt;
      rxbuf_r    <= rxbuf_nxt;
      edge_r     <= edge_nxt;
      busy_r     <= busy_nxt;
      msmp_r     <= msmp_nxt;
      mfin_r     <= mfin_nxt;
      div_r      <= div_nxt;
      sck_r      <= sck_nxt;
      sck_oe_r   <= sck_oe_nxt;
      mosi_oe_r  <= mosi_oe_nxt;
      miso_oe_r  <= miso_oe_nxt;
      err_irq_r  <= err_irq_nxt;
      ack_r      <= req;
      rdata_r    <= rdata_nxt;
    end
  end

  assign DAT_O      = {24'h000000, rdata_r};
  assign ACK_O      = ack_r;
  assign SCK_O      = sck_r;
  assign SCK_OE     = sck_oe_r;
  assign MOSI_O     = tx_r[7];
  assign MOSI_OE    = mosi_oe_r;
  assign MISO_O     = tx_r[7];
  assign MISO_OE    = miso_oe_r;
  assign TX_IRQ     = done_r;
  assign RX_ERR_IRQ = err_irq_r;

endmodule
`default_nettype wire

// file: dv/scr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scr_monitor (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [9:0]  ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic        WE_I,
  input wire logic        STB_I,
  input wire logic        CYC_I,
  input wire logic        ACK_O,
  input wire logic        SCK_O,
  input wire logic        SCK_OE,
  input wire logic        MOSI_OE,
  input wire logic        MISO_OE,
  input wire logic        RX_ERR_IRQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // ****************************************
  // Register bus
  // ****************************************
  a_ack_one_cycle : assert property (
    CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered next cycle");
  a_ack_single_pulse : assert property (
    ACK_O |=> !ACK_O)
    else $error("ack held past one cycle");
  a_no_ack_idle : assert property (
    !(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  a_status_rsvd_zero : assert property (
    ACK_O && !WE_I && ADR_I[9:2] == 8'hc4 |-> DAT_O[3:0] == 4'h0)
    else $error("status low nibble not zero");
  // ****************************************
  // Serial pins
  // ****************************************
  a_single_role : assert property (
    !(SCK_OE && MISO_OE))
    else $error("master and slave drivers both on");
  a_master_pins_pair : assert property (
    MOSI_OE == SCK_OE)
    else $error("clock and data drivers disagree");
  a_sck_half_min : assert property (
    SCK_OE && $changed(SCK_O) |=> $stable(SCK_O) || !SCK_OE)
    else $error("serial clock half shorter than two cycles");
  a_fault_drops_master : assert property (
    $rose(RX_ERR_IRQ) |-> ##[0:2] !SCK_OE)
    else $error("fault left master driving");
endmodule
`default_nettype wire

// file: dv/scr_partner.sv
`timescale 1ns/1ps
`default_nettype none
module scr_partner (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       sck_oe,
  input  wire logic       mosi,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_edge_phase,
  input  wire logic       active,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  int         edges = 0;
  logic       tog = 1'b0;
  logic       sck_last = 1'b0;
  logic [2:0] idx;
  always @(posedge clk) tog <= ~tog;
  // Event driven so the reply is not late by a clock
  always @(posedge active or sck) begin
    if (sck === sck_last) begin
      edges = 0;
    end else if (active && sck_oe) begin
      if (sck == (clock_idle_level == clock_edge_phase)) begin
        rx = {rx[6:0], mosi};
      end
      edges = edges + 1;
    end
    sck_last = sck;
  end
  assign idx = clock_edge_phase ? ((edges == 0) ? 3'h0 : 3'((edges - 1) / 2))
                    : 3'(edges / 2);
  // Deselected line keeps moving, never shows the last bit
  assign miso = active ? tx[3'h7 - idx] : tog;
endmodule
`default_nettype wire

// file: dv/scr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module scr_top_bench;
  localparam logic [9:0] CTL = {`SCR_IDX_CONTROL, 2'h0};
  localparam logic [9:0] STA = {`SCR_IDX_STATUS, 2'h0};
  localparam logic [9:0] DAT = {`SCR_IDX_DATA, 2'h0};
  logic        CLOCK, NRST, WE_I, STB_I, CYC_I, SEL_N_I, ACK_O, TX_IRQ;
  logic        SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_I, MISO_O, MISO_OE;
  logic        RX_ERR_IRQ, clock_idle_level, clock_edge_phase, act, s_sck, s_mosi;
  logic [9:0]  ADR_I;
  logic [31:0] DAT_I, DAT_O;
  logic [7:0]  q, tx, rx, b, rs, q2;
  int          seed, n_mismatch, cmp_count, n, dv;
  scr_top u_dut (.CLOCK(CLOCK), .NRST(NRST), .ADR_I(ADR_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(4'h1), .STB_I(STB_I), .CYC_I(CYC_I),
    .ACK_O(ACK_O), .SCK_I(s_sck), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
    .MOSI_I(s_mosi), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_I(MISO_I),
    .MISO_O(MISO_O), .MISO_OE(MISO_OE), .SEL_N_I(SEL_N_I),
    .TX_IRQ(TX_IRQ), .RX_ERR_IRQ(RX_ERR_IRQ));
  scr_partner u_partner (.clk(CLOCK), .sck(SCK_O), .sck_oe(SCK_OE),
    .mosi(MOSI_O), .clock_idle_level(clock_idle_level), .clock_edge_phase(clock_edge_phase), .active(act), .tx(tx),
    .miso(MISO_I), .rx(rx));
  always #2.5 CLOCK = ~CLOCK;
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge CLOCK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= {24'h0, d};
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (ACK_O !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    q = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // Bounded wait; n is cycles from the acked write
  task automatic wait_done;
    n = 0;
    while (TX_IRQ !== 1'b1 && n < 2000) begin
      @(posedge CLOCK);
      n++;
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 32'h8825;
    {CLOCK, NRST, WE_I, STB_I, CYC_I, clock_idle_level, clock_edge_phase, act} = 8'h00;
    {ADR_I, DAT_I, tx, SEL_N_I} = 51'h1;
    {s_sck, s_mosi} = 2'h0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    rdc(CTL, `SCR_CTL_RESET);
    wb(1'b0, STA, 8'h00);
    chk(q & 8'hd0, 8'h00);
    rdc(10'h3fc, 8'h00);
    // Every rate, modes cycling through all four
    for (int c = 1; c < 7; c++) begin
      dv = 4 << (c - 1);
      {clock_idle_level, clock_edge_phase} <= 2'(c);
      // Timing bits change only while the port is off
      wb(1'b1, CTL, {c[2], 3'h3, 2'(c), c[1:0]});
      wb(1'b1, CTL, {c[2], 3'h7, 2'(c), c[1:0]});
      tx <= 8'($random(seed));
      act <= 1'b1;
      b = 8'($random(seed));
      wb(1'b1, DAT, b);
      wait_done;
      act <= 1'b0;
      // Last sample lands two clocks late through the pin synchroniser
      chk(8'(n >= 8 * dv + 1 && n <= 8 * dv + 5), 8'h01);
      rdc(STA, 8'h80);
      rdc(DAT, tx);
      chk(rx, b);
      rdc(STA, 8'h00);
      chk(8'(SCK_O), 8'(clock_idle_level));
    end
    {clock_idle_level, clock_edge_phase} <= 2'h0;
    wb(1'b1, CTL, 8'h31);
    wb(1'b1, CTL, 8'h71);
    act <= 1'b1;
    wb(1'b1, DAT, 8'h5a);
    wb(1'b1, DAT, 8'ha5);
    wait_done;
    act <= 1'b0;
    rdc(STA, 8'hc0);
    wb(1'b0, DAT, 8'h00);
    rdc(STA, 8'h00);
    // Reserved rate: the write must not start anything
    wb(1'b1, CTL, 8'h70);
    wb(1'b1, DAT, 8'h3c);
    repeat (40) @(posedge CLOCK);
    chk(8'({TX_IRQ, SCK_O}), 8'h00);
    wb(1'b1, CTL, 8'h73);
    wb(1'b1, DAT, 8'h81);
    repeat (20) @(posedge CLOCK);
    wb(1'b1, CTL, 8'h33);
    repeat (2) @(posedge CLOCK);
    chk(8'(SCK_OE), 8'h00);
    repeat (200) @(posedge CLOCK);
    chk(8'(TX_IRQ), 8'h00);
    // Slave, phase 0: select stays in force despite the ignore bit
    wb(1'b1, CTL, 8'h60);
    b = 8'($random(seed));
    wb(1'b1, DAT, b);
    q2 = 8'($random(seed));
    SEL_N_I <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= q2[i];
      repeat (8) @(posedge CLOCK);
      rs = {rs[6:0], MISO_O};
      s_sck <= 1'b1;
      repeat (8) @(posedge CLOCK);
      s_sck <= 1'b0;
    end
    repeat (8) @(posedge CLOCK);
    SEL_N_I <= 1'b1;
    chk(rs, b);
    rdc(STA, 8'h80);
    rdc(DAT, q2);
    SEL_N_I <= 1'b0;
    repeat (8) @(posedge CLOCK);
    s_sck <= 1'b1;
    repeat (8) @(posedge CLOCK);
    SEL_N_I <= 1'b1;
    s_sck <= 1'b0;
    repeat (8) @(posedge CLOCK);
    rdc(STA, 8'h20);
    wb(1'b1, CTL, 8'h00);
    rdc(STA, 8'h00);
    wb(1'b1, CTL, 8'h51);
    SEL_N_I <= 1'b0;
    n = 0;
    while (RX_ERR_IRQ !== 1'b1 && n < 50) begin
      @(posedge CLOCK);
      n++;
    end
    chk(8'(RX_ERR_IRQ), 8'h01);
    rdc(CTL, 8'h01);
    rdc(STA, 8'h10);
    wb(1'b1, CTL, 8'h21);
    SEL_N_I <= 1'b1;
    rdc(STA, 8'h00);
    chk(8'(RX_ERR_IRQ), 8'h00);
    results;
  end
  initial begin
    #200000;
    n_mismatch++;
    results;
  end
endmodule
bind scr_top scr_monitor u_mon (.CLOCK(CLOCK), .NRST(NRST), .ADR_I(ADR_I),
  .DAT_O(DAT_O), .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
  .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE),
  .RX_ERR_IRQ(RX_ERR_IRQ));
`default_nettype wire
